// >>> design/beat_timer.sv
// watchdog on backend readiness between data beats
`default_nettype none
module beat_timer
  import tgt_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic run,
  input wire logic beat,
  output logic expired
);
  localparam logic [LAT_CNT_W-1:0] FIRST_LIM = LAT_CNT_W'(INIT_LAT_CLKS - 1);
  localparam logic [LAT_CNT_W-1:0] NEXT_LIM = LAT_CNT_W'(SUBSEQ_LAT_CLKS - 1);

  logic [LAT_CNT_W-1:0] cnt_q, lim_q;
  wire hit_lim = run & ~beat & (cnt_q == lim_q);

  // first beat gets the long limit, later beats the short one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      lim_q <= FIRST_LIM;
      expired <= 1'b0;
    end else begin
      expired <= hit_lim;
      if (arm) begin
        cnt_q <= '0;
        lim_q <= FIRST_LIM;
      end else if (beat) begin
        cnt_q <= '0;
        lim_q <= NEXT_LIM;
      end else if (run && !hit_lim) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/rd_fifo.sv
// flip-flop fifo with valid/ready on both sides
`default_nettype none
module rd_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [LVL_W-1:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // honest flags straight from the occupancy count
  assign in_ready = (cnt_q != FULL_LVL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign level = cnt_q;

  // one storage word per entry, written only at its own index
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[i] <= '0;
        end else if (push && wr_ptr_q == PTR_W'(i)) begin
          mem_q[i] <= in_data;
        end
      end
    end
  endgenerate

  // pointers wrap at the last entry, so depth need not be a power of 2
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_q + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> design/tgt_backend_port.sv
// backend port of a pci target: cycle flags, address, strobes, data
// Notes on behaviour
// - Region-zero flag high for hits on the base register at 10H.
// - Region-one flag high for hits on the base register at 14H.
// - Config flag high while the transaction targets configuration space.
// - Read flag high while the transaction reads from the backend.
// - Write flag high while the transaction writes to the backend.
// - Separate data in and out buses, word aligned, 32 or 64 bits.
// - Two active-high output enables, lower and upper lane of data out.
// - Word address is the pci byte address shifted right by two.
// - Word address width is a build-time parameter.
// - One-cycle start pulse when a backend transaction begins.
// - Wide start pulse in the same cycle as start for 64-bit.
// - One-cycle done pulse when a backend transaction ends successfully.
// - Read strobes only when backend read-ready and initiator ready both high.
// - Lower-lane read strobe always; upper-lane strobe only for 64-bit.
// - No read-ready within latency limit ends with disconnect, no data.
// - Cycle flags valid with start pulse, stable until done or disconnect pulse.
// - Latency count: address runs ahead, first that-many strobes carry no data.
`default_nettype none
module tgt_backend_port
  import tgt_port_pkg::*;
#(
  parameter int WORD_ADDR_BITS = WORD_ADDR_BITS_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_start,
  input wire tgt_port_pkg::txn_req_t req,
  input wire logic irdy_n,
  input wire logic frame_end,
  input wire logic pci_wr_valid,
  output logic pci_wr_ready,
  input wire tgt_port_pkg::wbeat_t pci_wr,
  output logic [tgt_port_pkg::DATA_W-1:0] pci_rdata,
  output logic pci_rdata_valid,
  input wire logic pci_rdata_ready,
  output logic disconnect_pulse,
  input wire logic backend_read_ready,
  input wire logic backend_write_ready,
  input wire logic [tgt_port_pkg::DATA_W-1:0] mem_din,
  input wire logic [tgt_port_pkg::PIPE_CNT_W-1:0] pipeline_latency_count,
  output logic region0_hit,
  output logic region1_hit,
  output logic cfg_space_hit,
  output logic backend_read_txn,
  output logic backend_write_txn,
  output logic xfer_begin_pulse,
  output logic wide_xfer_begin_pulse,
  output logic xfer_end_pulse,
  output logic [WORD_ADDR_BITS-1:0] mem_addr,
  output logic [tgt_port_pkg::DATA_W-1:0] mem_dout,
  output logic wdata_oe_low,
  output logic wdata_oe_high,
  output logic read_strobe_low,
  output logic read_strobe_high,
  output logic [tgt_port_pkg::BE_W-1:0] write_byte_strobes
);
  // the backend and the pci side drive every input from this same clock, so no
  // synchronisers sit on them

  port_state_t state_q, state_d;

  // transaction context
  logic wide_q;
  logic [WORD_ADDR_BITS-1:0] addr_q;
  logic [PIPE_CNT_W-1:0] skip_q;

  // registered outputs
  logic r0_q, r1_q, cfg_q, rd_q, wr_q;
  logic beg_q, beg64_q, end_q, disc_q;
  logic rstb_lo_q, rstb_hi_q;
  logic oe_lo_q, oe_hi_q;
  logic [DATA_W-1:0] dout_q;
  logic [BE_W-1:0] wbe_q;
  logic wr_rdy_q;
  logic [DATA_W-1:0] rhold_q;
  logic rhold_vld_q;

  // fifo handshake
  logic f_in_ready, f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_out_data;
  logic [RFIFO_LVL_W-1:0] f_level;
  logic tmo;

  // region decode from the matched base register offset
  wire hit0 = ~req.cfg & (req.bar_ofs == CFG_OFS_BASE0);
  wire hit1 = ~req.cfg & (req.bar_ofs == CFG_OFS_BASE1);

  // state decode
  wire in_idle = (state_q == ST_IDLE);
  wire in_rd = (state_q == ST_RD);
  wire in_wr = (state_q == ST_WR);
  wire take = in_idle & req_start;
  wire ini_rdy = ~irdy_n;

  // one strobe may be in flight, so keep one entry spare
  wire f_room = f_in_ready & (f_level <= RFIFO_ROOM_MAX);

  // read strobe needs both parties ready and room to land the data
  wire rd_go = in_rd & backend_read_ready & ini_rdy & f_room
    & ~frame_end & ~tmo;

  // write beat accepted from the pci side
  wire wr_go = in_wr & pci_wr_valid & wr_rdy_q & ini_rdy
    & ~frame_end & ~tmo;
  wire beat = rd_go | wr_go;

  // strobe in flight lands in the fifo unless still in the skip window
  wire rstb_any = rstb_lo_q;
  wire in_skip = (skip_q != '0);
  wire push = rstb_any & ~in_skip;

  // address step, two words per beat for 64-bit transfers
  wire [1:0] step = wide_q ? STEP_WIDE : STEP_NARROW;
  wire [WORD_ADDR_BITS-1:0] addr_next = addr_q + WORD_ADDR_BITS'(step);
  wire [WORD_ADDR_BITS-1:0] addr_start =
    req.addr[WORD_ADDR_BITS+WORD_SHIFT-1:WORD_SHIFT];

  // outcome of the active transaction
  wire ok_end = (in_rd | in_wr) & frame_end & ~tmo;
  wire bad_end = (in_rd | in_wr) & tmo;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_start) begin
          state_d = req.write ? ST_WR : ST_RD;
        end
      end
      ST_RD, ST_WR: begin
        if (tmo || frame_end) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cycle flags appear with the start pulse and hold until the end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r0_q <= 1'b0;
      r1_q <= 1'b0;
      cfg_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (take) begin
      r0_q <= hit0;
      r1_q <= hit1;
      cfg_q <= req.cfg;
      rd_q <= ~req.write;
      wr_q <= req.write;
    end else if (ok_end || bad_end) begin
      r0_q <= 1'b0;
      r1_q <= 1'b0;
      cfg_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
  end

  // framing pulses, each a single cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beg_q <= 1'b0;
      beg64_q <= 1'b0;
      end_q <= 1'b0;
      disc_q <= 1'b0;
    end else begin
      beg_q <= take;
      beg64_q <= take & req.wide;
      end_q <= ok_end;
      disc_q <= bad_end;
    end
  end

  // transaction context and word address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_q <= 1'b0;
      addr_q <= '0;
    end else if (take) begin
      wide_q <= req.wide;
      addr_q <= addr_start;
    end else if (beat) begin
      addr_q <= addr_next;
    end
  end

  // skip window: strobes issued while the backend pipe fills carry no
  // data, the address still runs ahead of them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= '0;
    end else if (take) begin
      skip_q <= pipeline_latency_count;
    end else if (rstb_any && in_skip) begin
      skip_q <= skip_q - 1'b1;
    end
  end

  // read strobes; upper lane only on wide transfers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstb_lo_q <= 1'b0;
      rstb_hi_q <= 1'b0;
    end else begin
      rstb_lo_q <= rd_go;
      rstb_hi_q <= rd_go & wide_q;
    end
  end

  // write side: ready is registered, so a beat taken now is driven to
  // the backend next cycle whatever its ready does then
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_rdy_q <= 1'b0;
    end else begin
      wr_rdy_q <= in_wr & backend_write_ready & ~frame_end;
    end
  end

  // write data and enables; reads never open the output drivers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      wbe_q <= '0;
      oe_lo_q <= 1'b0;
      oe_hi_q <= 1'b0;
    end else begin
      oe_lo_q <= wr_go;
      oe_hi_q <= wr_go & wide_q;
      if (wr_go) begin
        dout_q <= pci_wr.data;
        wbe_q <= wide_q ? pci_wr.be
          : {{LANE_W/8{1'b0}}, pci_wr.be[LANE_W/8-1:0]};
      end else begin
        wbe_q <= '0;
      end
    end
  end

  // the watchdog sees a beat on every read strobe issued or write beat taken, skip-window strobes included
  beat_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .arm(take),
    .run(in_rd | in_wr),
    .beat(beat),
    .expired(tmo)
  );

  // read data lands at the edge closing the strobe cycle
  rd_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(RFIFO_DEPTH),
    .LVL_W(RFIFO_LVL_W)
  ) u_rfifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(mem_din),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .level(f_level)
  );

  // output register toward the pci side; stalls back into the fifo
  assign f_out_ready = ~rhold_vld_q | pci_rdata_ready;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rhold_q <= '0;
      rhold_vld_q <= 1'b0;
    end else if (f_out_ready) begin
      rhold_vld_q <= f_out_valid;
      if (f_out_valid) begin
        rhold_q <= f_out_data;
      end
    end
  end

  // ports, all straight from flip-flops
  assign region0_hit = r0_q;
  assign region1_hit = r1_q;
  assign cfg_space_hit = cfg_q;
  assign backend_read_txn = rd_q;
  assign backend_write_txn = wr_q;
  assign xfer_begin_pulse = beg_q;
  assign wide_xfer_begin_pulse = beg64_q;
  assign xfer_end_pulse = end_q;
  assign disconnect_pulse = disc_q;
  assign mem_addr = addr_q;
  assign mem_dout = dout_q;
  assign wdata_oe_low = oe_lo_q;
  assign wdata_oe_high = oe_hi_q;
  assign read_strobe_low = rstb_lo_q;
  assign read_strobe_high = rstb_hi_q;
  assign write_byte_strobes = wbe_q;
  assign pci_wr_ready = wr_rdy_q;
  assign pci_rdata = rhold_q;
  assign pci_rdata_valid = rhold_vld_q;
endmodule
`default_nettype wire

// >>> design/tgt_port_pkg.sv
// shared constants, carriers and states of the target backend port
`default_nettype none
package tgt_port_pkg;
  // backend data path widths
  localparam int DATA_W = 64;
  localparam int LANE_W = 32;
  localparam int BE_W = 8;
  localparam int PCI_ADDR_W = 32;
  localparam int WORD_ADDR_BITS_DEF = 18;
  localparam int WORD_SHIFT = 2;
  // config header offsets of the two base address registers
  localparam logic [7:0] CFG_OFS_BASE0 = 8'h10;
  localparam logic [7:0] CFG_OFS_BASE1 = 8'h14;
  // address step per beat, in words
  localparam logic [1:0] STEP_NARROW = 2'h1;
  localparam logic [1:0] STEP_WIDE = 2'h2;
  // target latency limits, in clocks
  localparam int INIT_LAT_CLKS = 16;
  localparam int SUBSEQ_LAT_CLKS = 8;
  localparam int LAT_CNT_W = 5;
  // read fifo
  localparam int RFIFO_DEPTH = 8;
  localparam int RFIFO_LVL_W = 4;
  localparam logic [RFIFO_LVL_W-1:0] RFIFO_ROOM_MAX = 4'h6;
  localparam int PIPE_CNT_W = 3;

  // decoded transaction handed over by the pci target controller
  typedef struct packed {
    logic cfg;
    logic write;
    logic wide;
    logic [7:0] bar_ofs;
    logic [PCI_ADDR_W-1:0] addr;
  } txn_req_t;

  // one write beat from the pci side
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
  } wbeat_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD = 4'b0010,
    ST_WR = 4'b0100,
    ST_END = 4'b1000
  } port_state_t;
endpackage
`default_nettype wire

// >>> sim/backend_model.sv
// behavioural backend memory answering the port's read strobes
`default_nettype none
module backend_model
  import tgt_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic hold_off,
  input wire logic xfer_begin_pulse,
  input wire logic read_strobe_low,
  input wire logic [tgt_port_pkg::PIPE_CNT_W-1:0] pipeline_latency_count,
  output logic backend_read_ready,
  output logic backend_write_ready,
  output logic [tgt_port_pkg::DATA_W-1:0] mem_din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] idx_q;
  logic tick_q;
  logic [DATA_W-1:0] junk_q;
  logic [PIPE_CNT_W-1:0] skip_q;
  // readiness, paced every other cycle when slow
  assign backend_read_ready = !hold_off && (!slow || tick_q);
  assign backend_write_ready = !slow || tick_q;
  // whole words during a strobe, junk inverted every cycle otherwise
  // junk also while the pipe fills, so a wrongly kept word shows
  assign mem_din = (read_strobe_low && skip_q == '0) ?
    {8'hA5, idx_q, 8'h5A, idx_q} : junk_q;
  // word index restarts per transaction, on the port's own clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 24'h0;
      skip_q <= '0;
      tick_q <= 1'b0;
      junk_q <= 64'hF0F0_F0F0_0F0F_0F0F;
    end else begin
      tick_q <= ~tick_q;
      junk_q <= ~junk_q;
      if (xfer_begin_pulse) begin
        idx_q <= 24'h0;
        skip_q <= pipeline_latency_count;
      end else if (read_strobe_low && skip_q != '0) begin
        skip_q <= skip_q - 1'b1;
      end else if (read_strobe_low) begin
        idx_q <= idx_q + 24'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the target backend port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tgt_port_pkg::*;
  logic mclk, rst_n, req_start, irdy_n, frame_end, pci_wr_valid;
  logic pci_rdata_ready, slow, hold_off, pci_wr_ready, pci_rdata_valid;
  logic disconnect_pulse, backend_read_ready, backend_write_ready;
  logic region0_hit, region1_hit, cfg_space_hit, backend_read_txn;
  logic backend_write_txn, xfer_begin_pulse, wide_xfer_begin_pulse;
  logic xfer_end_pulse, wdata_oe_low, wdata_oe_high;
  logic read_strobe_low, read_strobe_high;
  logic [2:0] pipeline_latency_count;
  logic [17:0] mem_addr;
  logic [DATA_W-1:0] pci_rdata, mem_din, mem_dout;
  logic [BE_W-1:0] write_byte_strobes;
  txn_req_t req;
  wbeat_t pci_wr;
  int bad_count, num_checks;

  tgt_backend_port #(.WORD_ADDR_BITS(18)) dut (.*);
  backend_model be (.*);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(string name, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // a hang here ends the run rather than stalling it
  task automatic wait_for(string name, ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++) @(negedge mclk);
    if (sig !== 1'b1) begin
      bad_count++;
      $display("[ERR] %s expected 1 seen timeout", name);
      print_verdict();
    end
  endtask

  task automatic start_txn(logic cfg, logic wr, logic wide, logic [7:0] o);
    req = '{cfg: cfg, write: wr, wide: wide, bar_ofs: o,
      addr: 32'h000C_CCCC};
    req_start = 1'b1;
    @(negedge mclk);
    req_start = 1'b0;
    wait_for("begin", xfer_begin_pulse, 3);
    chk_val("region0", 64'(!cfg && o == 8'h10), 64'(region0_hit));
    chk_val("region1", 64'(!cfg && o == 8'h14), 64'(region1_hit));
    chk_val("cfg", 64'(cfg), 64'(cfg_space_hit));
    chk_val("rd", 64'(!wr), 64'(backend_read_txn));
    chk_val("wr", 64'(wr), 64'(backend_write_txn));
    chk_val("wide", 64'(wide), 64'(wide_xfer_begin_pulse));
    chk_val("addr", 64'h33333, 64'(mem_addr));
  endtask

  task automatic end_txn();
    frame_end = 1'b1;
    @(negedge mclk);
    frame_end = 1'b0;
    wait_for("end", xfer_end_pulse, 3);
    chk_val("flags", 64'h0, 64'({region0_hit, region1_hit,
      cfg_space_hit, backend_read_txn, backend_write_txn}));
    @(negedge mclk);
    chk_val("end width", 64'h0, 64'(xfer_end_pulse));
    @(negedge mclk);
  endtask

  // drain n words, refusing them for the first stall cycles
  task automatic read_words(int n, logic wide, int stall);
    int k;
    int s;
    logic [63:0] m;
    k = 0;
    s = 0;
    m = wide ? '1 : 64'hFFFF_FFFF;
    for (int c = 0; c < 200 && k < n; c++) begin
      pci_rdata_ready = (c >= stall);
      if (c < stall && read_strobe_low === 1'b1) s++;
      if (read_strobe_low === 1'b1) begin
        chk_val("strobe hi", 64'(wide), 64'(read_strobe_high));
      end
      if (pci_rdata_valid === 1'b1 && pci_rdata_ready) begin
        chk_val("rdata", {8'hA5, 24'(k), 8'h5A, 24'(k)} & m,
          pci_rdata & m);
        k++;
      end
      @(negedge mclk);
    end
    chk_val("words", 64'(n), 64'(k));
    // a stall fills the fifo and the output register, then strobes stop
    chk_val("fifo cap", 64'(stall != 0 ? RFIFO_DEPTH + 1 : 0),
      64'(s));
  endtask

  task automatic write_beat(logic wide, logic [63:0] d, logic [7:0] b);
    logic [63:0] m;
    m = wide ? '1 : 64'hFFFF_FFFF;
    pci_wr = '{data: d, be: b};
    pci_wr_valid = 1'b1;
    wait_for("wr ready", pci_wr_ready, 20);
    @(negedge mclk);
    pci_wr_valid = 1'b0;
    chk_val("dout", d & m, mem_dout & m);
    // narrow beats carry only the lower lane's byte strobes
    chk_val("be", 64'(wide ? b : {4'h0, b[3:0]}),
      64'(write_byte_strobes));
    chk_val("oe", 64'({wide, 1'b1}),
      64'({wdata_oe_high, wdata_oe_low}));
    chk_val("addr step", 64'h33333 + 64'(wide ? STEP_WIDE : STEP_NARROW),
      64'(mem_addr));
    @(negedge mclk);
    chk_val("oe idle", 64'h0,
      64'({wdata_oe_high, wdata_oe_low}));
  endtask

  task automatic t_read_full();
    start_txn(1'b0, 1'b0, 1'b0, 8'h10);
    read_words(10, 1'b0, 12);
    end_txn();
    $display("narrow read with full buffer done");
  endtask

  task automatic t_read_cfg_wide();
    slow = 1'b1;
    pipeline_latency_count = 3'h2;
    start_txn(1'b1, 1'b0, 1'b1, 8'h00);
    read_words(4, 1'b1, 0);
    end_txn();
    slow = 1'b0;
    pipeline_latency_count = 3'h0;
    $display("paced wide config read done");
  endtask

  task automatic t_write_narrow();
    start_txn(1'b0, 1'b1, 1'b0, 8'h14);
    write_beat(1'b0, 64'h1234_5678_9ABC_DEF0, 8'hF5);
    end_txn();
    $display("narrow write done");
  endtask

  task automatic t_write_wide();
    start_txn(1'b0, 1'b1, 1'b1, 8'h10);
    write_beat(1'b1, 64'hCAFE_0001_BEEF_0002, 8'h3C);
    end_txn();
    $display("wide write done");
  endtask

  task automatic t_timeout();
    hold_off = 1'b1;
    start_txn(1'b0, 1'b0, 1'b0, 8'h14);
    wait_for("disconnect", disconnect_pulse, 40);
    chk_val("no done", 64'h0, 64'(xfer_end_pulse));
    chk_val("no data", 64'h0, 64'(pci_rdata_valid));
    hold_off = 1'b0;
    repeat (2) @(negedge mclk);
    $display("silent backend disconnect done");
  endtask

  initial begin
    rst_n = 1'b0;
    req_start = 1'b0;
    req = '0;
    irdy_n = 1'b1;
    frame_end = 1'b0;
    pci_wr_valid = 1'b0;
    pci_wr = '0;
    pci_rdata_ready = 1'b1;
    slow = 1'b0;
    hold_off = 1'b0;
    pipeline_latency_count = 3'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    irdy_n = 1'b0;
    @(negedge mclk);
    t_read_full();
    t_write_narrow();
    t_read_cfg_wide();
    t_write_wide();
    t_timeout();
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> sim/tgt_port_props.sv
// assertion checker for the target backend port
`default_nettype none
module tgt_port_props
  import tgt_port_pkg::*;
#(
  parameter int WORD_ADDR_BITS = 18
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_start,
  input wire tgt_port_pkg::txn_req_t req,
  input wire logic irdy_n,
  input wire logic frame_end,
  input wire logic pci_wr_valid,
  input wire logic pci_wr_ready,
  input wire logic disconnect_pulse,
  input wire logic backend_read_ready,
  input wire logic region0_hit,
  input wire logic region1_hit,
  input wire logic cfg_space_hit,
  input wire logic backend_read_txn,
  input wire logic backend_write_txn,
  input wire logic xfer_begin_pulse,
  input wire logic wide_xfer_begin_pulse,
  input wire logic xfer_end_pulse,
  input wire logic [WORD_ADDR_BITS-1:0] mem_addr,
  input wire logic wdata_oe_low,
  input wire logic wdata_oe_high,
  input wire logic read_strobe_low,
  input wire logic read_strobe_high
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // region decode the request should produce
  wire r0_exp = !req.cfg && req.bar_ofs == CFG_OFS_BASE0;
  wire r1_exp = !req.cfg && req.bar_ofs == CFG_OFS_BASE1;
  sequence s_begin;
    xfer_begin_pulse;
  endsequence
  sequence s_wbeat;
    pci_wr_valid && pci_wr_ready && !irdy_n;
  endsequence
  // eight cycles of an open read with the backend silent
  sequence s_rstall;
    (backend_read_txn && !backend_read_ready && !frame_end)[*8];
  endsequence

  begin_cause_a: assert property (
    s_begin |-> $past(req_start) ##1 !xfer_begin_pulse)
    else $error("begin pulse without request");
  wide_begin_a: assert property (
    wide_xfer_begin_pulse == (xfer_begin_pulse && $past(req.wide)))
    else $error("wide begin pulse wrong");
  region_decode_a: assert property (
    s_begin |-> region0_hit == $past(r0_exp)
      && region1_hit == $past(r1_exp))
    else $error("region flag wrong");
  cfg_flag_a: assert property (
    s_begin |-> cfg_space_hit == $past(req.cfg))
    else $error("config flag wrong");
  dir_flag_a: assert property (
    s_begin |-> backend_write_txn == $past(req.write)
      && backend_read_txn == !$past(req.write))
    else $error("direction flag wrong");
  flag_hold_a: assert property (
    $fell(backend_read_txn) || $fell(backend_write_txn)
      |-> xfer_end_pulse || disconnect_pulse)
    else $error("cycle flag dropped early");
  addr_shift_a: assert property (
    s_begin |-> mem_addr == $past(req.addr[WORD_ADDR_BITS+1:2]))
    else $error("word address wrong");
  strobe_qual_a: assert property (
    read_strobe_low |-> $past(backend_read_ready && !irdy_n))
    else $error("read strobe without both ready");
  strobe_pair_a: assert property (
    read_strobe_high |-> read_strobe_low && backend_read_txn)
    else $error("upper strobe alone");
  oe_cause_a: assert property (
    wdata_oe_low || wdata_oe_high |-> backend_write_txn
      && $past(pci_wr_valid && pci_wr_ready && !irdy_n))
    else $error("output enable without write beat");
  beat_oe_a: assert property (
    s_wbeat ##0 (backend_write_txn && !frame_end) |=> wdata_oe_low)
    else $error("write beat without output enable");
  end_cause_a: assert property (
    xfer_end_pulse |-> $past(frame_end) && !disconnect_pulse)
    else $error("done pulse without frame end");
  rd_timeout_a: assert property (
    s_begin ##0 s_rstall ##1 s_rstall |-> ##[0:3] disconnect_pulse)
    else $error("no disconnect on silent backend");
endmodule

bind tgt_backend_port tgt_port_props #(
  .WORD_ADDR_BITS(WORD_ADDR_BITS)
) props (.*);
`default_nettype wire
